// ### fpa_addr_decode.sv
/*
  Decodes the operation-select field into an operation kind and the
  effective flash address, dropping the bits each operation ignores.
  Assumes the select code and target address are stable when sampled.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fpa_defs.svh"

module fpa_addr_decode
  import fpa_pkg::*;
(
  input wire logic [3:0] operation_select,
  input wire logic [31:0] flash_target_address,
  output fpa_kind_t kind,
  output logic [31:0] effective_address
);

  // Kind and masked address per operation
  always_comb begin
    kind = fpa_kind_reserved;
    effective_address = `FPA_RST_WORD;
    unique case (operation_select)
      `FPA_OP_PAGE: begin
        kind = fpa_kind_page;
        effective_address = flash_target_address & `FPA_MASK_PAGE;
      end
      `FPA_OP_ROW: begin
        kind = fpa_kind_row;
        effective_address = flash_target_address & `FPA_MASK_ROW;
      end
      `FPA_OP_DWORD: begin
        kind = fpa_kind_dword;
        effective_address = flash_target_address & `FPA_MASK_DWORD;
      end
      `FPA_OP_ERASE_ALL: begin
        kind = fpa_kind_erase_all;
      end
      `FPA_OP_NONE: begin
        kind = fpa_kind_none;
      end
      default: begin
        kind = fpa_kind_reserved;
      end
    endcase
  end

endmodule // fpa_addr_decode

`default_nettype wire

// ### fpa_defs.svh
/*
  Constants of the flash programming operand block: register offsets,
  field positions, reset values and operation-select codes.
  Assumes it is included by bare name wherever a number is needed.
*/
`ifndef FPA_DEFS_SVH
`define FPA_DEFS_SVH

// Register byte offsets on the register bus
`define FPA_OFS_TARGET 8'h00
`define FPA_OFS_DATA_LOW 8'h04
`define FPA_OFS_DATA_HIGH 8'h08
`define FPA_OFS_SOURCE 8'h0C
`define FPA_OFS_PROTECT 8'h10
`define FPA_OFS_STATUS 8'h14

// Reset values
`define FPA_RST_WORD 32'h0000_0000
`define FPA_RST_BOUNDARY 24'h00_0000
`define FPA_RST_UNLOCK 1'b1

// Write-protect register fields
`define FPA_PROT_UNLOCK_BIT 31
`define FPA_PROT_BOUND_MSB 23
`define FPA_PROT_BOUND_LSB 0

// Operation-select codes
`define FPA_OP_NONE 4'h0
`define FPA_OP_DWORD 4'h2
`define FPA_OP_ROW 4'h3
`define FPA_OP_PAGE 4'h4
`define FPA_OP_ERASE_ALL 4'h7

// Disregarded low target address bits per operation
`define FPA_MASK_PAGE 32'hFFFF_F800
`define FPA_MASK_ROW 32'hFFFF_FF00
`define FPA_MASK_DWORD 32'hFFFF_FFF8

// Program flash region and page geometry for the protection compare
`define FPA_PFM_REGION 8'h1D
`define FPA_PAGE_LSB 11

// Status register fields
`define FPA_STAT_OP_LSB 0
`define FPA_STAT_PROT_BIT 8
`define FPA_STAT_DONE_BIT 9

`endif

// ### fpa_operand_regs.sv
/*
  Operand registers of the flash programming controller behind an APB
  slave: target address, two data words, row source address and the
  program flash write-protect register, plus a read-only status word.
  On a start pulse it latches a complete operand set for the sequencer.
  Assumes presetn is power-on reset, sys_reset_pulse marks any other
  reset, and operation_select/flash_write_start come from the control
  logic that owns the unlock sequence.
  A misaligned double-word target is masked, not refused: software is
  expected to align it, and nothing here flags a stray low bit.
  Likewise a start is never refused here; the sequencer reads the
  latched protection flag and decides for itself.
*/
// The placing of the registers and the APB register port were chosen for this implementation.
// Notes on behaviour
// - Page erase ignores target address bits 10:0
// - Row program ignores target address bits 7:0
// - Double-word program ignores target bits 2:0
// - Other operations do not use target address
// - Double-word writes high word then low word
// - Low data word is least significant word
// - Row program fetches from source address register
// - Operand registers clear only on power-on reset
// - Protect: lock bit 31 set, boundary 23:0 zero
// - Codes: 4 page, 3 row, 2 dword, 7 all
// - Locked protect register refuses writes until reset
// - Protect pages up to boundary; zero disables
`timescale 1ns/1ps
`default_nettype none
`include "fpa_defs.svh"

module fpa_operand_regs
  import fpa_pkg::*;
(
  input wire logic pclk, // 20 MHz bus clock
  input wire logic presetn, // Power-on reset, active low
  input wire logic sys_reset_pulse, // Any other reset, one cycle
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic [3:0] operation_select, // Operation code from control
  input wire logic flash_write_start, // Operation trigger, one cycle
  output logic cmd_valid, // Operand set valid, one cycle
  output fpa_cmd_t cmd, // Latched operand set
  output logic protect_hit_now // Current target is protected
);

  // One copy of every operand, shared by the read mux and the latch
  // Stored registers
  logic [31:0] flash_target_address; // Target flash address
  logic [31:0] flash_write_data_low; // Low data word
  logic [31:0] flash_write_data_high; // High data word
  logic [31:0] row_source_address; // Row program source
  logic protect_unlock; // Protect register lock control
  logic [23:0] protect_boundary; // Protect boundary field
  logic [3:0] last_op; // Code of the last operation started
  logic op_seen; // Any operation started since power-on

  // Next values
  // Worked out by the combinational processes, registered once below
  logic [31:0] next_flash_target_address;
  logic [31:0] next_flash_write_data_low;
  logic [31:0] next_flash_write_data_high;
  logic [31:0] next_row_source_address;
  logic next_protect_unlock;
  logic [23:0] next_protect_boundary;
  logic [3:0] next_last_op;
  logic next_op_seen;
  logic [31:0] next_prdata;
  logic next_cmd_valid;
  fpa_cmd_t next_cmd;

  // Bus decode
  logic setup_phase; // First cycle of a transfer
  logic access_phase; // Completing cycle of a transfer
  logic wr_en; // Write takes effect this edge
  logic addr_hit; // Address maps to a register

  // Decoded operation
  // Recomputed from the live registers on every cycle
  fpa_kind_t kind; // Operation kind
  logic [31:0] effective_address; // Target with ignored bits dropped
  logic protect_hit; // Protection compare result

  // pready follows the access phase, so every transfer takes two cycles;
  // an unmapped address still completes, flagged by pslverr
  // Zero wait state: read data prepared during setup
  always_comb begin
    setup_phase = psel && !penable;
    access_phase = psel && penable;
    pready = access_phase;
    wr_en = access_phase && pwrite && addr_hit;
    pslverr = access_phase && !addr_hit;
  end

  // Address map check
  // Status is read-only but mapped, so a write there completes quietly
  // instead of raising an error
  always_comb begin
    unique case (paddr)
      `FPA_OFS_TARGET,
      `FPA_OFS_DATA_LOW,
      `FPA_OFS_DATA_HIGH,
      `FPA_OFS_SOURCE,
      `FPA_OFS_PROTECT,
      `FPA_OFS_STATUS: begin
        addr_hit = 1'b1;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  // Operation kind and effective address
  // Only the masked copy goes to the sequencer; the register itself
  // keeps every bit that software wrote
  fpa_addr_decode u_decode (
    .operation_select(operation_select),
    .flash_target_address(flash_target_address),
    .kind(kind),
    .effective_address(effective_address)
  );

  // Write-protect compare on the effective address
  // Bulk erase is judged against the boundary as a whole
  fpa_protect_check u_protect (
    .effective_address(effective_address),
    .protect_boundary(protect_boundary),
    .erase_all(kind == fpa_kind_erase_all),
    .protect_hit(protect_hit)
  );

  // Live flag for control logic that wants to refuse a start early
  assign protect_hit_now = protect_hit;

  // Register write next values
  // Writes land at the access edge. The lock bit only falls by software;
  // any other reset raises it again and wins over a same-cycle write,
  // so a locked boundary is never stuck past a warm reset
  always_comb begin
    next_flash_target_address = flash_target_address;
    next_flash_write_data_low = flash_write_data_low;
    next_flash_write_data_high = flash_write_data_high;
    next_row_source_address = row_source_address;
    next_protect_unlock = protect_unlock;
    next_protect_boundary = protect_boundary;
    if (wr_en) begin
      unique case (paddr)
        `FPA_OFS_TARGET: begin
          next_flash_target_address = pwdata;
        end
        `FPA_OFS_DATA_LOW: begin
          next_flash_write_data_low = pwdata;
        end
        `FPA_OFS_DATA_HIGH: begin
          next_flash_write_data_high = pwdata;
        end
        `FPA_OFS_SOURCE: begin
          next_row_source_address = pwdata;
        end
        `FPA_OFS_PROTECT: begin
          if (protect_unlock) begin
            // Lock can only be cleared by software
            // Boundary and lock move together while the register is open
            next_protect_unlock = pwdata[`FPA_PROT_UNLOCK_BIT];
            next_protect_boundary = pwdata[`FPA_PROT_BOUND_MSB:`FPA_PROT_BOUND_LSB];
          end
        end
        default: begin
          // Status is read-only; writes are dropped
        end
      endcase
    end
    // Warm reset reopens the protect register, even over a write
    if (sys_reset_pulse) begin
      next_protect_unlock = `FPA_RST_UNLOCK;
    end
  end

  // Operand registers; only power-on reset clears them
  // sys_reset_pulse is left out on purpose, so that software's operands
  // survive a warm reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_target_address <= `FPA_RST_WORD;
      flash_write_data_low <= `FPA_RST_WORD;
      flash_write_data_high <= `FPA_RST_WORD;
      row_source_address <= `FPA_RST_WORD;
      protect_unlock <= `FPA_RST_UNLOCK;
      protect_boundary <= `FPA_RST_BOUNDARY;
    end else begin
      flash_target_address <= next_flash_target_address;
      flash_write_data_low <= next_flash_write_data_low;
      flash_write_data_high <= next_flash_write_data_high;
      row_source_address <= next_row_source_address;
      protect_unlock <= next_protect_unlock;
      protect_boundary <= next_protect_boundary;
    end
  end

  // Read mux, sampled in the setup cycle
  // Captured at the setup edge, so prdata already stands through the
  // whole access cycle and holds until the next setup
  always_comb begin
    next_prdata = prdata;
    if (setup_phase) begin
      unique case (paddr)
        `FPA_OFS_TARGET: begin
          next_prdata = flash_target_address;
        end
        `FPA_OFS_DATA_LOW: begin
          next_prdata = flash_write_data_low;
        end
        `FPA_OFS_DATA_HIGH: begin
          next_prdata = flash_write_data_high;
        end
        `FPA_OFS_SOURCE: begin
          next_prdata = row_source_address;
        end
        `FPA_OFS_PROTECT: begin
          // Bits 30:24 unimplemented, read as zero
          next_prdata = `FPA_RST_WORD;
          next_prdata[`FPA_PROT_UNLOCK_BIT] = protect_unlock;
          next_prdata[`FPA_PROT_BOUND_MSB:`FPA_PROT_BOUND_LSB] = protect_boundary;
        end
        `FPA_OFS_STATUS: begin
          next_prdata = `FPA_RST_WORD;
          // Last code, live protection, any start since power-on
          next_prdata[`FPA_STAT_OP_LSB +: 4] = last_op;
          next_prdata[`FPA_STAT_PROT_BIT] = protect_hit;
          next_prdata[`FPA_STAT_DONE_BIT] = op_seen;
        end
        default: begin
          // Unmapped: zero, beside pslverr
          next_prdata = `FPA_RST_WORD;
        end
      endcase
    end
  end

  // Read data register
  // Cleared at power-on only; otherwise keeps the last word read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `FPA_RST_WORD;
    end else begin
      prdata <= next_prdata;
    end
  end

  // Operand set latched on the start pulse
  // Frozen at the start edge so software may load the next operands
  // while the sequencer is still busy; the source address goes out
  // only for a row program, other kinds see zero
  always_comb begin
    next_cmd_valid = flash_write_start;
    next_cmd = cmd;
    next_last_op = last_op;
    next_op_seen = op_seen;
    if (flash_write_start) begin
      next_last_op = operation_select;
      next_op_seen = 1'b1;
      next_cmd.kind = kind;
      next_cmd.address = effective_address;
      next_cmd.protect_hit = protect_hit;
      // High word above low word in the double word
      next_cmd.data = {flash_write_data_high, flash_write_data_low};
      if (kind == fpa_kind_row) begin
        next_cmd.source = row_source_address;
      end else begin
        // Only a row program reads from system memory
        next_cmd.source = `FPA_RST_WORD;
      end
    end
  end

  // Command output and status registers
  // cmd_valid is a one-cycle strobe; cmd stands until the next start
  // so the sequencer may take it whenever it is ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_valid <= 1'b0;
      cmd <= '0;
      last_op <= `FPA_OP_NONE;
      op_seen <= 1'b0;
    end else begin
      cmd_valid <= next_cmd_valid;
      cmd <= next_cmd;
      last_op <= next_last_op;
      op_seen <= next_op_seen;
    end
  end

endmodule // fpa_operand_regs

`default_nettype wire

// ### fpa_operand_regs_monitor.sv
/*
  Checker of the operand block's APB answer and command outputs.
  Assumes it is bound to fpa_operand_regs and sees its ports only.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fpa_defs.svh"

module fpa_operand_regs_monitor
  import fpa_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pslverr,
  input wire logic pready,
  input wire logic [3:0] operation_select,
  input wire logic flash_write_start,
  input wire logic cmd_valid,
  input wire fpa_cmd_t cmd,
  input wire logic protect_hit_now
);
  // All checks on the bus clock, off during reset
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic go = flash_write_start; // Short name for the trigger
  wire logic [3:0] op = operation_select; // Short name for the code

  AST_RDY: assert property (pready == (psel && penable))
    else $error("pready not in access phase");
  AST_ERR: assert property (pslverr |-> pready)
    else $error("pslverr outside access");
  AST_VLD: assert property (go |=> cmd_valid)
    else $error("no cmd_valid after start");
  AST_ONE: assert property (cmd_valid |-> $past(go))
    else $error("cmd_valid without start");
  AST_HOLD: assert property (!go |=> $stable(cmd))
    else $error("cmd moved without start");
  AST_PAGE: assert property (go && op == `FPA_OP_PAGE |=>
    cmd.kind == fpa_kind_page && cmd.address[10:0] == 11'h000)
    else $error("page address not masked");
  AST_ROW: assert property (go && op == `FPA_OP_ROW |=>
    cmd.kind == fpa_kind_row && cmd.address[7:0] == 8'h00)
    else $error("row address not masked");
  AST_DW: assert property (go && op == `FPA_OP_DWORD |=>
    cmd.kind == fpa_kind_dword && cmd.address[2:0] == 3'h0)
    else $error("dword address not masked");
  AST_IGN: assert property (go && !(op inside {4'h2, 4'h3, 4'h4}) |=>
    cmd.address == 32'h0000_0000)
    else $error("address used by other op");
  AST_PROT: assert property (go |=> cmd.protect_hit == $past(protect_hit_now))
    else $error("protect_hit not latched");
endmodule // fpa_operand_regs_monitor

bind fpa_operand_regs fpa_operand_regs_monitor mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pslverr(pslverr), .pready(pready),
  .operation_select(operation_select), .flash_write_start(flash_write_start),
  .cmd_valid(cmd_valid), .cmd(cmd), .protect_hit_now(protect_hit_now));
`default_nettype wire

// ### fpa_operand_regs_test.sv
/*
  Self-checking bench of the operand block over APB and the start input.
  Assumes the checker is bound in by its own file.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fpa_defs.svh"

module fpa_operand_regs_test
  import fpa_pkg::*;
;
  logic pclk = 1'b0; // Bus clock
  logic presetn = 1'b0; // Power-on reset
  logic sys_reset_pulse = 1'b0; // Other reset
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] operation_select = 4'h0;
  logic flash_write_start = 1'b0;
  logic cmd_valid;
  fpa_cmd_t cmd;
  logic protect_hit_now;
  logic [31:0] rd; // Last read data
  logic er; // Last pslverr
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0;

  fpa_operand_regs uut (.pclk(pclk), .presetn(presetn),
    .sys_reset_pulse(sys_reset_pulse), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .operation_select(operation_select),
    .flash_write_start(flash_write_start), .cmd_valid(cmd_valid), .cmd(cmd),
    .protect_hit_now(protect_hit_now));

  // 50 ns clock
  always #25 pclk = ~pclk;

  // Hang guard
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask

  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk("read", {32'h0, exp}, {32'h0, rd});
  endtask

  // Start pulse, then look at the one-cycle answer
  task automatic start(input logic [3:0] op);
    @(posedge pclk);
    operation_select <= op;
    flash_write_start <= 1'b1;
    @(posedge pclk);
    flash_write_start <= 1'b0;
    #1 chk("cmd_valid", 64'h1, {63'h0, cmd_valid});
    @(posedge pclk);
    #1 chk("cmd_valid_end", 64'h0, {63'h0, cmd_valid});
  endtask

  // Reset values and an unmapped address
  task automatic t_reset();
    rdc(`FPA_OFS_TARGET, 32'h0000_0000);
    rdc(`FPA_OFS_DATA_LOW, 32'h0000_0000);
    rdc(`FPA_OFS_DATA_HIGH, 32'h0000_0000);
    rdc(`FPA_OFS_SOURCE, 32'h0000_0000);
    rdc(`FPA_OFS_PROTECT, 32'h8000_0000);
    apb(1'b0, 8'h18, 32'h0000_0000);
    chk("pslverr", 64'h1, {63'h0, er});
    chk("rd_unmapped", 64'h0, {32'h0, rd});
  endtask

  // Each defined operation code and one reserved code against a misaligned target
  task automatic t_ops();
    logic [3:0] ops [6] = '{4'h4, 4'h3, 4'h2, 4'h0, 4'h7, 4'h5};
    fpa_kind_t kinds [6] = '{fpa_kind_page, fpa_kind_row, fpa_kind_dword,
      fpa_kind_none, fpa_kind_erase_all, fpa_kind_reserved};
    logic [31:0] msk [6] = '{32'hFFFF_F800, 32'hFFFF_FF00, 32'hFFFF_FFF8,
      32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
    wr(`FPA_OFS_SOURCE, 32'h2000_0100);
    wr(`FPA_OFS_DATA_LOW, 32'h1111_2222);
    wr(`FPA_OFS_DATA_HIGH, 32'h3333_4444);
    wr(`FPA_OFS_TARGET, 32'h1D00_17FF);
    for (int i = 0; i < 6; i++) begin
      start(ops[i]);
      chk("kind", {61'h0, kinds[i]}, {61'h0, cmd.kind});
      chk("addr", {32'h0, 32'h1D00_17FF & msk[i]}, {32'h0, cmd.address});
      chk("data", 64'h3333_4444_1111_2222, cmd.data);
      chk("src", (i == 1) ? 64'h2000_0100 : 64'h0, {32'h0, cmd.source});
    end
    rdc(`FPA_OFS_TARGET, 32'h1D00_17FF);
    rdc(`FPA_OFS_STATUS, 32'h0000_0205);
    // Lawful double-word: software keeps the target 64-bit aligned
    wr(`FPA_OFS_TARGET, 32'h1D00_17F8);
    start(4'h2);
    chk("addr_aligned", 64'h1D00_17F8, {32'h0, cmd.address});
  endtask

  // Boundary compare, lock and the non-POR reset
  task automatic t_protect();
    wr(`FPA_OFS_PROTECT, 32'hFFFF_FFFF);
    rdc(`FPA_OFS_PROTECT, 32'h80FF_FFFF);
    wr(`FPA_OFS_PROTECT, 32'h8000_1000);
    wr(`FPA_OFS_TARGET, 32'h1D00_1000);
    start(4'h4);
    chk("hit_in", 64'h1, {63'h0, cmd.protect_hit});
    wr(`FPA_OFS_TARGET, 32'h1D00_1800);
    start(4'h4);
    chk("hit_out", 64'h0, {63'h0, cmd.protect_hit});
    start(4'h7);
    chk("hit_all", 64'h1, {63'h0, cmd.protect_hit});
    wr(`FPA_OFS_PROTECT, 32'h0000_2000);
    wr(`FPA_OFS_PROTECT, 32'h8000_0000);
    rdc(`FPA_OFS_PROTECT, 32'h0000_2000);
    @(posedge pclk);
    operation_select <= 4'h4;
    #1 chk("hit_now", 64'h1, {63'h0, protect_hit_now});
    @(posedge pclk);
    sys_reset_pulse <= 1'b1;
    @(posedge pclk);
    sys_reset_pulse <= 1'b0;
    rdc(`FPA_OFS_PROTECT, 32'h8000_2000);
    rdc(`FPA_OFS_TARGET, 32'h1D00_1800);
    rdc(`FPA_OFS_DATA_HIGH, 32'h3333_4444);
    wr(`FPA_OFS_PROTECT, 32'h8000_0000);
    start(4'h7);
    chk("hit_off", 64'h0, {63'h0, cmd.protect_hit});
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_ops();
    t_protect();
    end_of_test();
  end
endmodule // fpa_operand_regs_test
`default_nettype wire

// ### fpa_pkg.sv
/*
  Types of the flash programming operand block.
  Assumes fpa_defs.svh is compiled alongside for the numbers.
*/
package fpa_pkg;

  // Kind of flash operation decoded from the operation-select field
  typedef enum logic [2:0] {
    fpa_kind_none,
    fpa_kind_dword,
    fpa_kind_row,
    fpa_kind_page,
    fpa_kind_erase_all,
    fpa_kind_reserved
  } fpa_kind_t;

  // Operand set handed to the flash sequencer
  typedef struct packed {
    fpa_kind_t kind;
    logic [31:0] address;
    logic [63:0] data;
    logic [31:0] source;
    logic protect_hit;
  } fpa_cmd_t;

endpackage

// ### fpa_protect_check.sv
/*
  Compares an effective flash address against the program flash
  write-protect boundary. Pages at and below the boundary page are
  protected; a zero boundary turns protection off.
  Assumes addresses are system physical addresses.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fpa_defs.svh"

module fpa_protect_check (
  input wire logic [31:0] effective_address,
  input wire logic [23:0] protect_boundary,
  input wire logic erase_all,
  output logic protect_hit
);

  // Page numbers inside the program flash region
  logic [23:`FPA_PAGE_LSB] target_page; // Page of the target
  logic [23:`FPA_PAGE_LSB] bound_page; // Page holding the boundary
  logic in_region; // Target lies in program flash
  logic enabled; // Non-zero boundary

  // Protection compare
  always_comb begin
    target_page = effective_address[23:`FPA_PAGE_LSB];
    bound_page = protect_boundary[23:`FPA_PAGE_LSB];
    in_region = (effective_address[31:24] == `FPA_PFM_REGION);
    enabled = (protect_boundary != `FPA_RST_BOUNDARY);
    if (!enabled) begin
      protect_hit = 1'b0;
    end else if (erase_all) begin
      protect_hit = 1'b1; // Bulk erase needs every page open
    end else begin
      protect_hit = in_region && (target_page <= bound_page);
    end
  end

endmodule // fpa_protect_check

`default_nettype wire
